// >>> pkg/ltmt_map.svh
// Timing counts for the host-side controller of a dual single-wire LIN channel
`ifndef LTMT_MAP_SVH
`define LTMT_MAP_SVH

`define LTMT_CHANNELS 2
`define LTMT_CLK_MHZ 25
`define LTMT_FIFO_DEPTH 8
`define LTMT_DATA_W 8
`define LTMT_FRAME_BITS 10

// Limits in the unit named by each suffix
`define LTMT_SLEEP_ENTRY_DELAY_MAX_NS 91000
`define LTMT_ENABLE_WAKE_DELAY_MAX_NS 15000
`define LTMT_FIRST_DOMINANT_DELAY_MAX_MS 80
`define LTMT_DOMINANT_TIMEOUT_MIN_US 3750
`define LTMT_TOGGLE_EN_LOW_MAX_NS 45000
`define LTMT_TOGGLE_STEP_MIN_NS 12500
`define LTMT_FAST_ACK_MIN_NS 1875
`define LTMT_FAST_ACK_MAX_NS 6250

// Derived cycle counts: least times round up, longest times round down
`define LTMT_CYC_UP(ns) (((ns) * `LTMT_CLK_MHZ + 999) / 1000)
`define LTMT_CYC_DN(ns) (((ns) * `LTMT_CLK_MHZ) / 1000)
`define LTMT_SLEEP_CYC `LTMT_CYC_DN(`LTMT_SLEEP_ENTRY_DELAY_MAX_NS)
`define LTMT_WAKE_CYC `LTMT_CYC_DN(`LTMT_ENABLE_WAKE_DELAY_MAX_NS)
`define LTMT_FIRST_DOM_CYC (`LTMT_FIRST_DOMINANT_DELAY_MAX_MS * `LTMT_CLK_MHZ * 1000)
`define LTMT_DOM_LIMIT_CYC (`LTMT_DOMINANT_TIMEOUT_MIN_US * `LTMT_CLK_MHZ)
`define LTMT_TOGGLE_MAX_CYC `LTMT_CYC_DN(`LTMT_TOGGLE_EN_LOW_MAX_NS)
`define LTMT_STEP_CYC `LTMT_CYC_UP(`LTMT_TOGGLE_STEP_MIN_NS)
`define LTMT_ACK_MIN_CYC `LTMT_CYC_UP(`LTMT_FAST_ACK_MIN_NS)
`define LTMT_ACK_MAX_CYC `LTMT_CYC_DN(`LTMT_FAST_ACK_MAX_NS)
// Two synchroniser stages plus the saw_q register that holds the seen acknowledge
`define LTMT_ACK_WIN_CYC (`LTMT_ACK_MAX_CYC + 3)
`define LTMT_BIT_CYC_DEFAULT 1250

`endif

// >>> pkg/ltmt_pkg.sv
// Types for the host-side LIN channel controller
package ltmt_pkg;
    typedef enum logic [3:0] {
        LTMT_ENTER_SLEEP = 4'h0,
        LTMT_ASLEEP = 4'h1,
        LTMT_WAKING = 4'h3,
        LTMT_SETTLE = 4'h2,
        LTMT_NORMAL = 4'h6,
        LTMT_TOG_EN = 4'h7,
        LTMT_TOG_TX = 4'h5,
        LTMT_TOG_REL = 4'h4,
        LTMT_TOG_CHK = 4'hC
    } ltmt_state_t;
    typedef logic [23:0] ltmt_count_t;
endpackage : ltmt_pkg

// >>> hdl/ltmt_fifo.sv
// Parameterised valid/ready FIFO used in each channel's transmit path
`timescale 1ns/1ps
`default_nettype none
module ltmt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and control
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;
    logic ready_q, ready_d;

    // Ready is registered so the top-level port comes straight from a flop
    assign in_ready = ready_q;
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? wr_q + (AW+1)'(1) : wr_q;
        rd_d = pop ? rd_q + (AW+1)'(1) : rd_q;
        ready_d = (wr_d[AW] == rd_d[AW]) || (wr_d[AW-1:0] != rd_d[AW-1:0]);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            ready_q <= 1'b1;
        end else if (clk_en) begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            ready_q <= ready_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule : ltmt_fifo
`default_nettype wire

// >>> hdl/ltmt_ctrl.sv
// Host controller driving two LIN transceiver channels through enable and transmit pins
// Operation
// - Fast-baud enable low pulse at most 45 us
// - Fast-baud transmit low at least 12.5 us
// - Enable fall to transmit fall at least 12.5 us
// - Transmit rise to enable rise at least 12.5 us
// - Enable high normal; long low means sleep
`include "ltmt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ltmt_ctrl #(
    parameter int FIRST_DOM_CYC = `LTMT_FIRST_DOM_CYC,
    parameter int DOM_LIMIT_CYC = `LTMT_DOM_LIMIT_CYC,
    parameter int BIT_CYC = `LTMT_BIT_CYC_DEFAULT
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Commands, one bit per channel, one-cycle pulses
    input wire logic [`LTMT_CHANNELS-1:0] cmd_wake,
    input wire logic [`LTMT_CHANNELS-1:0] cmd_sleep,
    input wire logic [`LTMT_CHANNELS-1:0] cmd_fast,
    // Transmit bytes, one lane per channel
    input wire logic [`LTMT_CHANNELS-1:0] tx_valid,
    output logic [`LTMT_CHANNELS-1:0] tx_ready,
    input wire logic [`LTMT_CHANNELS*`LTMT_DATA_W-1:0] tx_data,
    // Transceiver pins
    output logic [`LTMT_CHANNELS-1:0] en_pin,
    output logic [`LTMT_CHANNELS-1:0] txd_pin,
    input wire logic [`LTMT_CHANNELS-1:0] rxd_pin,
    // Status
    output logic [`LTMT_CHANNELS-1:0] ch_normal,
    output logic [`LTMT_CHANNELS-1:0] ch_asleep,
    output logic [`LTMT_CHANNELS-1:0] ch_fast,
    output logic [`LTMT_CHANNELS-1:0] rx_level,
    output logic [`LTMT_CHANNELS-1:0] wake_seen,
    output logic [`LTMT_CHANNELS-1:0] fast_done,
    output logic [`LTMT_CHANNELS-1:0] fast_fail
);
    import ltmt_pkg::*;

    for (genvar i = 0; i < `LTMT_CHANNELS; i++) begin : g_ch
        ltmt_state_t state_q, state_d;
        ltmt_count_t cnt_q, cnt_d;
        logic en_q, en_d, txd_q, txd_d;
        logic [`LTMT_FRAME_BITS-1:0] sh_q, sh_d;
        logic [3:0] bits_q, bits_d;
        logic [15:0] bcnt_q, bcnt_d;
        logic [16:0] dom_q, dom_d;
        logic fast_q, fast_d, saw_q, saw_d;
        logic normal_q, normal_d, asleep_q, asleep_d;
        logic wake_q, wake_d, done_q, done_d, fail_q, fail_d;
        logic rx_q;
        logic sync1_q, sync2_q;
        logic fifo_valid, fifo_pop;
        logic [`LTMT_DATA_W-1:0] fifo_data;

        ltmt_fifo #(
            .WIDTH(`LTMT_DATA_W),
            .DEPTH(`LTMT_FIFO_DEPTH)
        ) u_fifo (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .in_valid(tx_valid[i]),
            .in_ready(tx_ready[i]),
            .in_data(tx_data[i*`LTMT_DATA_W +: `LTMT_DATA_W]),
            .out_valid(fifo_valid),
            .out_ready(fifo_pop),
            .out_data(fifo_data)
        );

        // Frames start only once the validation delay is over
        assign fifo_pop = (state_q == LTMT_NORMAL) && (bits_q == 4'h0) && !cmd_sleep[i]
            && !cmd_fast[i];

        always_comb begin
            state_d = state_q;
            cnt_d = cnt_q + 24'h00_0001;
            en_d = en_q;
            sh_d = sh_q;
            bits_d = bits_q;
            bcnt_d = bcnt_q;
            fast_d = fast_q;
            saw_d = saw_q;
            wake_d = 1'b0;
            done_d = 1'b0;
            fail_d = 1'b0;
            txd_d = 1'b1;
            case (state_q)
                LTMT_ENTER_SLEEP: begin
                    en_d = 1'b0;
                    bits_d = 4'h0;
                    // Device drops inhibit by this time unless local wake moved
                    if (cnt_q >= 24'(`LTMT_SLEEP_CYC)) begin
                        state_d = LTMT_ASLEEP;
                        fast_d = 1'b0;
                    end
                end
                LTMT_ASLEEP: begin
                    en_d = 1'b0;
                    if (!sync2_q || cmd_wake[i]) begin
                        wake_d = !sync2_q;
                        state_d = LTMT_WAKING;
                        en_d = 1'b1;
                        cnt_d = 24'h00_0000;
                    end
                end
                LTMT_WAKING: begin
                    if (cnt_q >= 24'(`LTMT_WAKE_CYC)) begin
                        state_d = LTMT_SETTLE;
                        cnt_d = 24'h00_0000;
                    end
                end
                LTMT_SETTLE: begin
                    if (cnt_q >= 24'(FIRST_DOM_CYC)) begin
                        state_d = LTMT_NORMAL;
                    end
                end
                LTMT_NORMAL: begin
                    cnt_d = cnt_q;
                    if (bits_q != 4'h0) begin
                        txd_d = sh_q[0];
                        if (bcnt_q >= 16'(BIT_CYC - 1)) begin
                            bcnt_d = 16'h0000;
                            sh_d = {1'b1, sh_q[`LTMT_FRAME_BITS-1:1]};
                            bits_d = bits_q - 4'h1;
                        end else begin
                            bcnt_d = bcnt_q + 16'h0001;
                        end
                    end else if (fifo_pop && fifo_valid) begin
                        sh_d = {1'b1, fifo_data, 1'b0};
                        bits_d = 4'(`LTMT_FRAME_BITS);
                        bcnt_d = 16'h0000;
                    end else if (cmd_fast[i]) begin
                        state_d = LTMT_TOG_EN;
                        en_d = 1'b0;
                        cnt_d = 24'h00_0000;
                    end
                end
                LTMT_TOG_EN: begin
                    if (cnt_q >= 24'(`LTMT_STEP_CYC)) begin
                        state_d = LTMT_TOG_TX;
                        txd_d = 1'b0;
                        cnt_d = 24'h00_0000;
                    end
                end
                LTMT_TOG_TX: begin
                    txd_d = 1'b0;
                    if (cnt_q >= 24'(`LTMT_STEP_CYC)) begin
                        state_d = LTMT_TOG_REL;
                        txd_d = 1'b1;
                        cnt_d = 24'h00_0000;
                    end
                end
                LTMT_TOG_REL: begin
                    // Three steps stay well inside the longest enable-low pulse
                    if (cnt_q >= 24'(`LTMT_STEP_CYC)) begin
                        state_d = LTMT_TOG_CHK;
                        en_d = 1'b1;
                        saw_d = 1'b0;
                        cnt_d = 24'h00_0000;
                    end
                end
                LTMT_TOG_CHK: begin
                    if (!sync2_q) begin
                        saw_d = 1'b1;
                    end
                    if (cnt_q >= 24'(`LTMT_ACK_WIN_CYC)) begin
                        state_d = LTMT_NORMAL;
                        if (saw_q != fast_q) begin
                            fast_d = !fast_q;
                            done_d = 1'b1;
                        end else begin
                            fail_d = 1'b1;
                        end
                    end
                end
                default: begin
                    state_d = LTMT_ENTER_SLEEP;
                    en_d = 1'b0;
                    cnt_d = 24'h00_0000;
                end
            endcase
            if (cmd_sleep[i] && (state_q == LTMT_NORMAL || state_q == LTMT_SETTLE
                || state_q == LTMT_WAKING)) begin
                state_d = LTMT_ENTER_SLEEP;
                en_d = 1'b0;
                bits_d = 4'h0;
                txd_d = 1'b1;
                cnt_d = 24'h00_0000;
            end
            // Never hold dominant long enough to trip the device timeout
            dom_d = txd_q ? 17'h0_0000 : dom_q + 17'h0_0001;
            if (!txd_q && dom_q >= 17'(DOM_LIMIT_CYC - 2)) begin
                txd_d = 1'b1;
            end
            normal_d = (state_d == LTMT_NORMAL);
            asleep_d = (state_d == LTMT_ASLEEP);
        end

        always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
                state_q <= LTMT_ENTER_SLEEP;
                cnt_q <= 24'h00_0000;
                en_q <= 1'b0;
                txd_q <= 1'b1;
                sh_q <= '1;
                bits_q <= 4'h0;
                bcnt_q <= 16'h0000;
                dom_q <= 17'h0_0000;
                fast_q <= 1'b0;
                saw_q <= 1'b0;
                normal_q <= 1'b0;
                asleep_q <= 1'b0;
                wake_q <= 1'b0;
                done_q <= 1'b0;
                fail_q <= 1'b0;
                rx_q <= 1'b1;
                sync1_q <= 1'b1;
                sync2_q <= 1'b1;
            end else if (clk_en) begin
                state_q <= state_d;
                cnt_q <= cnt_d;
                en_q <= en_d;
                txd_q <= txd_d;
                sh_q <= sh_d;
                bits_q <= bits_d;
                bcnt_q <= bcnt_d;
                dom_q <= dom_d;
                fast_q <= fast_d;
                saw_q <= saw_d;
                normal_q <= normal_d;
                asleep_q <= asleep_d;
                wake_q <= wake_d;
                done_q <= done_d;
                fail_q <= fail_d;
                rx_q <= sync2_q;
                sync1_q <= rxd_pin[i];
                sync2_q <= sync1_q;
            end
        end

        assign en_pin[i] = en_q;
        assign txd_pin[i] = txd_q;
        assign ch_normal[i] = normal_q;
        assign ch_asleep[i] = asleep_q;
        assign ch_fast[i] = fast_q;
        assign rx_level[i] = rx_q;
        assign wake_seen[i] = wake_q;
        assign fast_done[i] = done_q;
        assign fast_fail[i] = fail_q;
    end
endmodule : ltmt_ctrl
`default_nettype wire

// >>> sim/ltmt_checker.sv
// Port-level assertions for the LIN channel controller
`timescale 1ns/1ps
`default_nettype none
module ltmt_checker #(
    parameter int FIRST_DOM_CYC = 50,
    parameter int DOM_LIMIT_CYC = 2000,
    parameter int BIT_CYC = 20
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pins and status
    input wire logic [1:0] en_pin,
    input wire logic [1:0] txd_pin,
    input wire logic [1:0] ch_asleep,
    input wire logic [1:0] ch_fast,
    input wire logic [1:0] fast_done
);
    int en_lo_q;
    int txd_lo_q;
    int txd_hi_q;
    int wake_hi_q;
    logic tog_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Run lengths of channel 0 pins; wake count restarts only on a non-toggle enable rise
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            en_lo_q <= 0;
            txd_lo_q <= 0;
            txd_hi_q <= 0;
            wake_hi_q <= 0;
            tog_q <= 1'b0;
        end else begin
            en_lo_q <= en_pin[0] ? 0 : en_lo_q + 1;
            txd_lo_q <= txd_pin[0] ? 0 : txd_lo_q + 1;
            txd_hi_q <= txd_pin[0] ? txd_hi_q + 1 : 0;
            wake_hi_q <= (en_pin[0] && en_lo_q > 0 && !tog_q) ? 0 : wake_hi_q + 1;
            tog_q <= en_pin[0] ? 1'b0 : (tog_q || !txd_pin[0]);
        end
    end
    property p_tog_lead;
        $fell(txd_pin[0]) && !en_pin[0] |-> en_lo_q >= 313;
    endproperty
    a_tog_lead: assert property (p_tog_lead) else $error("txd fell early");
    property p_tog_txlow;
        $rose(txd_pin[0]) && !en_pin[0] |-> txd_lo_q >= 313;
    endproperty
    a_tog_txlow: assert property (p_tog_txlow) else $error("txd low too short");
    property p_tog_trail;
        $rose(en_pin[0]) |-> txd_hi_q >= 313;
    endproperty
    a_tog_trail: assert property (p_tog_trail) else $error("en rose early");
    property p_tog_enlow;
        $rose(en_pin[0]) && tog_q |-> en_lo_q <= 1125;
    endproperty
    a_tog_enlow: assert property (p_tog_enlow) else $error("en low too long");
    property p_sleep_wait;
        $rose(ch_asleep[0]) |-> !en_pin[0] && en_lo_q >= 2275;
    endproperty
    a_sleep_wait: assert property (p_sleep_wait) else $error("asleep too soon");
    property p_first_dom;
        $fell(txd_pin[0]) && en_pin[0] |-> wake_hi_q >= FIRST_DOM_CYC;
    endproperty
    a_first_dom: assert property (p_first_dom) else $error("dominant too soon");
    property p_dom_guard;
        !txd_pin[0] |-> txd_lo_q < DOM_LIMIT_CYC;
    endproperty
    a_dom_guard: assert property (p_dom_guard) else $error("dominant too long");
    property p_fast_ack;
        $changed(ch_fast[0]) && en_pin[0] |-> fast_done[0];
    endproperty
    a_fast_ack: assert property (p_fast_ack) else $error("fast flag without done");
endmodule : ltmt_checker
bind ltmt_ctrl ltmt_checker #(.FIRST_DOM_CYC(FIRST_DOM_CYC), .DOM_LIMIT_CYC(DOM_LIMIT_CYC),
    .BIT_CYC(BIT_CYC)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .en_pin(en_pin),
    .txd_pin(txd_pin), .ch_asleep(ch_asleep), .ch_fast(ch_fast), .fast_done(fast_done));
`default_nettype wire

// >>> sim/ltmt_dev_model.sv
// Behavioural model of the two-channel transceiver facing the controller
`timescale 1ns/1ps
`default_nettype none
module ltmt_dev_model #(
    parameter int SLP = 1750,
    parameter int WUF = 1750,
    parameter int WF = 1200,
    parameter int FDOM = 50,
    parameter int DOM = 93750,
    parameter int ACK = 100
) (
    // Clock
    input wire logic sys_clk,
    // Controller pins
    input wire logic [1:0] en_pin,
    input wire logic [1:0] txd_pin,
    output logic [1:0] rxd_pin,
    // Other bus nodes, local wake switches and fast-ack suppression
    input wire logic [1:0] bus_dom,
    input wire logic [1:0] wake_in,
    input wire logic [1:0] no_ack
);
    int en_lo[2], en_hi[2], tx_lo[2], wf_c[2], bw_c[2], ack_c[2];
    logic [1:0] asleep = 0, flag = 0, wref = 0, fast = 0, tog = 0, fd_ok = 0, dom_ok = 1;
    logic [1:0] ack_on = 0;
    logic [1:0] inhibit_out;
    // Pins sampled mid-cycle so receive changes never race the controller's flops
    always @(negedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (en_pin[i] && en_lo[i] > 0) begin
                if (asleep[i]) begin
                    asleep[i] = 1'b0;
                    flag[i] = 1'b0;
                end else if (tog[i] && en_lo[i] <= 1125 && !no_ack[i]) begin
                    fast[i] = !fast[i];
                    ack_c[i] = fast[i] ? ACK : 0;
                end
                tog[i] = 1'b0;
            end
            if (!en_pin[i] && en_lo[i] == 0) wref[i] = wake_in[i];
            if (!asleep[i] && !en_pin[i] && en_lo[i] >= SLP && wake_in[i] == wref[i]) begin
                asleep[i] = 1'b1;
                fast[i] = 1'b0;
            end
            wf_c[i] = (asleep[i] && wake_in[i] != wref[i]) ? wf_c[i] + 1 : 0;
            bw_c[i] = (asleep[i] && bus_dom[i]) ? bw_c[i] + 1 : 0;
            if (wf_c[i] >= WF || bw_c[i] >= WUF) flag[i] = 1'b1;
            if (!en_pin[i] && !txd_pin[i] && !asleep[i]) tog[i] = 1'b1;
            if (ack_c[i] > 0) ack_c[i]--;
            en_lo[i] = en_pin[i] ? 0 : en_lo[i] + 1;
            en_hi[i] = asleep[i] ? 0 : en_hi[i] + 1;
            tx_lo[i] = txd_pin[i] ? 0 : tx_lo[i] + 1;
            fd_ok[i] = en_hi[i] >= FDOM;
            dom_ok[i] = tx_lo[i] < DOM;
            ack_on[i] = ack_c[i] > 0;
        end
    end
    // Released receive pin reads high through the pull-up
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            inhibit_out[i] = !asleep[i];
            rxd_pin[i] = asleep[i] ? !flag[i] : !ack_on[i] && !(bus_dom[i] ||
                (en_pin[i] && !txd_pin[i] && fd_ok[i] && dom_ok[i]));
        end
    end
endmodule : ltmt_dev_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the LIN channel controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
    logic sys_clk = 0, reset_n = 0;
    logic [1:0] cmd_wake = 0, cmd_sleep = 0, cmd_fast = 0, tx_valid = 0;
    logic [1:0] bus_dom = 0, wake_in = 0, no_ack = 0;
    logic [15:0] tx_data = 0;
    logic [1:0] tx_ready, en_pin, txd_pin, rxd_pin, ch_normal, ch_asleep, ch_fast;
    logic [1:0] rx_level, wake_seen, fast_done, fast_fail;
    int fails = 0, checks_done = 0;
    always #20 sys_clk = ~sys_clk;
    ltmt_ctrl #(.FIRST_DOM_CYC(50), .DOM_LIMIT_CYC(2000), .BIT_CYC(20)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .cmd_wake(cmd_wake),
        .cmd_sleep(cmd_sleep), .cmd_fast(cmd_fast), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .en_pin(en_pin), .txd_pin(txd_pin),
        .rxd_pin(rxd_pin), .ch_normal(ch_normal), .ch_asleep(ch_asleep),
        .ch_fast(ch_fast), .rx_level(rx_level), .wake_seen(wake_seen),
        .fast_done(fast_done), .fast_fail(fast_fail));
    ltmt_dev_model u_dev (.sys_clk(sys_clk), .en_pin(en_pin), .txd_pin(txd_pin),
        .rxd_pin(rxd_pin), .bus_dom(bus_dom), .wake_in(wake_in), .no_ack(no_ack));
    task automatic wait_on(input int k, input int ch, input int lim, output bit hit);
        logic [1:0] v;
        hit = 0;
        repeat (lim) begin
            @(negedge sys_clk);
            v = k == 0 ? ch_normal : k == 1 ? ch_asleep : k == 2 ? wake_seen :
                k == 3 ? fast_done : fast_fail;
            if (v[ch] === 1'b1) begin
                hit = 1;
                break;
            end
        end
    endtask : wait_on
    task automatic cmd(input int k, input int ch);
        @(posedge sys_clk);
        if (k == 0) cmd_wake[ch] <= 1'b1;
        if (k == 1) cmd_sleep[ch] <= 1'b1;
        if (k == 2) cmd_fast[ch] <= 1'b1;
        @(posedge sys_clk);
        cmd_wake <= 2'b00;
        cmd_sleep <= 2'b00;
        cmd_fast <= 2'b00;
    endtask : cmd
    task automatic push(input int ch, input logic [7:0] d, output bit ok);
        @(posedge sys_clk);
        tx_valid[ch] <= 1'b1;
        tx_data[8*ch +: 8] <= d;
        ok = 0;
        repeat (3) begin
            @(posedge sys_clk);
            if (tx_ready[ch] === 1'b1) begin
                ok = 1;
                break;
            end
        end
        tx_valid[ch] <= 1'b0;
    endtask : push
    task automatic frame(input int ch, input logic [9:0] f);
        bit hit;
        hit = 0;
        repeat (3000) begin
            @(negedge sys_clk);
            if (txd_pin[ch] === 1'b0) begin
                hit = 1;
                break;
            end
        end
        `CHK("frame start", 1'b1, hit)
        repeat (10) @(negedge sys_clk);
        `CHK("rx start", 1'b0, rx_level[ch])
        for (int b = 0; b < 10; b++) begin
            `CHK("txd bit", f[b], txd_pin[ch])
            repeat (20) @(negedge sys_clk);
        end
    endtask : frame
    task automatic summarize;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    initial begin
        bit hit;
        int n;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_on(1, 0, 3000, hit);
        `CHK("asleep", 2'b11, {ch_asleep[1], hit})
        `CHK("pins idle", 4'b0011, {en_pin, txd_pin})
        `CHK("inhibit off", 2'b00, u_dev.inhibit_out)
        n = 0;
        for (int i = 0; i < 9; i++) begin
            push(1, 8'h30 + i[7:0], hit);
            n += hit;
        end
        `CHK("fifo fill", 8, n)
        $display("test sleep and fill done");
        cmd(0, 0);
        @(negedge sys_clk);
        `CHK("en on", 1'b1, en_pin[0])
        wait_on(0, 0, 600, hit);
        `CHK("normal", 2'b11, {ch_asleep[1], hit})
        `CHK("inhibit on", 2'b01, u_dev.inhibit_out)
        push(0, 8'hA5, hit);
        frame(0, {1'b1, 8'hA5, 1'b0});
        $display("test wake and frame done");
        for (int j = 0; j < 3; j++) begin
            no_ack[0] <= (j == 2);
            cmd(2, 0);
            wait_on(j == 2 ? 4 : 3, 0, 1500, hit);
            @(negedge sys_clk);
            `CHK("fast step", 2'b11, {hit, ch_fast[0] ^ (j != 0)})
        end
        no_ack[0] <= 1'b0;
        $display("test fast toggle done");
        bus_dom[1] <= 1'b1;
        wait_on(2, 1, 2500, hit);
        bus_dom[1] <= 1'b0;
        `CHK("bus wake", 1'b1, hit)
        frame(1, {1'b1, 8'h30, 1'b0});
        // Seven queued frames hold 37 dominant bits; half a start bit is already past
        n = 0;
        repeat (1800) begin
            @(negedge sys_clk);
            n += !txd_pin[1];
        end
        `CHK("queued low cycles", 730, n)
        `CHK("fifo drained", 1'b1, tx_ready[1])
        $display("test bus wake done");
        cmd(1, 0);
        wait_on(1, 0, 3000, hit);
        wake_in[0] <= 1'b1;
        repeat (100) @(posedge sys_clk);
        wake_in[0] <= 1'b0;
        repeat (1500) @(negedge sys_clk);
        `CHK("glitch ignored", 2'b11, {hit, ch_asleep[0]})
        wake_in[0] <= 1'b1;
        wait_on(2, 0, 2000, hit);
        `CHK("local wake", 1'b1, hit)
        $display("test local wake done");
        summarize;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        summarize;
    end
endmodule : tb_top
`default_nettype wire
